//--- tef_pkg.sv
// Package with constants and carrier types of the timer event flag logic
package tef_pkg;

  localparam int          TEF_CNT_W     = 16;
  localparam int          TEF_NUM_CH    = 2;
  localparam logic [15:0] TEF_CNT_ZERO  = 16'h0000;
  localparam logic [15:0] TEF_CNT_ONES  = 16'hFFFF;
  localparam logic [15:0] TEF_CNT_ONE   = 16'h0001;
  localparam logic [15:0] TEF_MOD_FREE  = 16'h0000;
  localparam logic        TEF_FLAG_RST  = 1'b0;
  localparam logic        TEF_EN_RST    = 1'b0;

  // Channel operating modes
  typedef enum logic [1:0]
  {
    TEF_CH_CAPTURE = 2'b00,
    TEF_CH_COMPARE = 2'b01,
    TEF_CH_PWM     = 2'b10
  } tef_ch_mode_t;

  // Edge select field: high bit, low bit
  typedef enum logic [1:0]
  {
    TEF_EDGE_OFF  = 2'b00,
    TEF_EDGE_RISE = 2'b01,
    TEF_EDGE_FALL = 2'b10,
    TEF_EDGE_ANY  = 2'b11
  } tef_edge_t;

  // Software access to one flag: read strobe and write-zero strobe
  typedef struct packed
  {
    logic rd;
    logic wr_zero;
  } tef_clr_t;

  // Per-channel configuration
  typedef struct packed
  {
    tef_ch_mode_t    mode;
    tef_edge_t       edge_sel;
    logic [15:0]     value;
  } tef_ch_cfg_t;

endpackage : tef_pkg

//--- tef_flag.sv
// One event flag with its two-step read-then-write-zero clearing sequence
`timescale 1ns/1ns
module tef_flag
  import tef_pkg::*;
(
  input  wire logic     i_clk,
  input  wire logic     i_rstn,
  input  wire logic     i_set,
  input  wire tef_clr_t i_clr,
  output logic          o_flag
);

  logic flag_ff;
  logic armed_ff;
  logic nxt_flag;
  logic nxt_armed;

  // --------------------------------------------------------------------
  // Clearing sequence
  // --------------------------------------------------------------------
  always_comb
  begin
    nxt_flag  = flag_ff;
    nxt_armed = armed_ff;
    if (i_set)
    begin
      // A new event restarts the sequence; set beats clear
      nxt_flag  = 1'b1;
      nxt_armed = 1'b0;
    end
    else
    begin
      if (i_clr.wr_zero && armed_ff)
      begin
        nxt_flag  = 1'b0;
        nxt_armed = 1'b0;
      end
      else if (i_clr.rd && flag_ff)
        nxt_armed = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      flag_ff  <= TEF_FLAG_RST;
      armed_ff <= 1'b0;
    end
    else
    begin
      flag_ff  <= nxt_flag;
      armed_ff <= nxt_armed;
    end
  end

  assign o_flag = flag_ff;

endmodule : tef_flag

//--- tef_event_flags.sv
// Counter wrap and channel event flags of a 16-bit timer/PWM unit
`timescale 1ns/1ns
module tef_event_flags
  import tef_pkg::*;
#(
  parameter int NUM_CH = TEF_NUM_CH
)
(
  input  wire logic                     i_clk,
  input  wire logic                     i_rstn,
  input  wire logic                     i_count_en,
  input  wire logic [15:0]              i_modulus,
  input  wire logic                     i_centered_pwm_select,
  input  wire tef_ch_cfg_t [NUM_CH-1:0] i_ch_cfg,
  input  wire logic [NUM_CH-1:0]        i_ch_pin,
  input  wire logic                     i_wrap_irq_enable,
  input  wire logic [NUM_CH-1:0]        i_channel_irq_enable,
  input  wire tef_clr_t                 i_wrap_clr,
  input  wire tef_clr_t [NUM_CH-1:0]    i_ch_clr,
  output logic [15:0]                   o_count,
  output logic                          o_count_down,
  output logic                          o_counter_wrap_flag,
  output logic [NUM_CH-1:0]             o_channel_event_flag,
  output logic                          o_wrap_irq,
  output logic [NUM_CH-1:0]             o_channel_irq
);

  // --------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------
  function automatic logic edge_hit(input tef_edge_t sel,
                                    input logic      prev,
                                    input logic      cur);
    logic rise;
    logic fall;
    rise = !prev && cur;
    fall = prev && !cur;
    case (sel)
      TEF_EDGE_RISE: edge_hit = rise;
      TEF_EDGE_FALL: edge_hit = fall;
      TEF_EDGE_ANY:  edge_hit = rise || fall;
      default:       edge_hit = 1'b0;
    endcase
  endfunction : edge_hit

  // --------------------------------------------------------------------
  // Counter
  // --------------------------------------------------------------------
  logic [15:0] cnt_ff;
  logic        down_ff;
  logic [15:0] nxt_cnt;
  logic        nxt_down;
  logic        wrap_evt;
  logic [15:0] top;

  // Modulus of zero means free running over the whole range when i_centered_pwm_select is low; centered mode compares with i_modulus itself
  assign top = (i_modulus == TEF_MOD_FREE) ? TEF_CNT_ONES : i_modulus;

  always_comb
  begin
    nxt_cnt  = cnt_ff;
    nxt_down = down_ff;
    wrap_evt = 1'b0;
    if (i_count_en)
    begin
      if (!i_centered_pwm_select)
      begin
        nxt_down = 1'b0;
        if (cnt_ff == top)
        begin
          nxt_cnt  = TEF_CNT_ZERO;
          wrap_evt = 1'b1;
        end
        else
          nxt_cnt = cnt_ff + TEF_CNT_ONE;
      end
      else if (!down_ff)
      begin
        if (cnt_ff >= i_modulus)
        begin
          // Reversal at the top ends a period
          nxt_down = 1'b1;
          nxt_cnt  = cnt_ff - TEF_CNT_ONE;
          wrap_evt = 1'b1;
        end
        else
          nxt_cnt = cnt_ff + TEF_CNT_ONE;
      end
      else
      begin
        if (cnt_ff == TEF_CNT_ZERO)
        begin
          // Zero is the centre; turn and count up again
          nxt_down = 1'b0;
          nxt_cnt  = TEF_CNT_ONE;
        end
        else
          nxt_cnt = cnt_ff - TEF_CNT_ONE;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      cnt_ff <= TEF_CNT_ZERO;
    else
      cnt_ff <= nxt_cnt;
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      down_ff <= 1'b0;
    else
      down_ff <= nxt_down;
  end

  // --------------------------------------------------------------------
  // Channel input synchronisers
  // --------------------------------------------------------------------
  logic [NUM_CH-1:0] pin_meta_ff;
  logic [NUM_CH-1:0] pin_sync_ff;
  logic [NUM_CH-1:0] pin_prev_ff;

  // Pins are asynchronous; only the second and third stages feed the edge logic
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
      pin_prev_ff <= '0;
    end
    else
    begin
      pin_meta_ff <= i_ch_pin;
      pin_sync_ff <= pin_meta_ff;
      pin_prev_ff <= pin_sync_ff;
    end
  end

  // --------------------------------------------------------------------
  // Channel events
  // --------------------------------------------------------------------
  logic [NUM_CH-1:0] ch_evt;

  always_comb
  begin
    ch_evt = '0;
    for (int i = 0; i < NUM_CH; i++)
    begin
      case (i_ch_cfg[i].mode)
        TEF_CH_CAPTURE:
          ch_evt[i] = edge_hit(i_ch_cfg[i].edge_sel,
                               pin_prev_ff[i], pin_sync_ff[i]);
        TEF_CH_COMPARE:
          ch_evt[i] = i_count_en
                      && (cnt_ff == i_ch_cfg[i].value);
        TEF_CH_PWM:
          // Edge mode matches once per period, centered mode matches
          // once going up and once going down
          ch_evt[i] = i_count_en
                      && (cnt_ff == i_ch_cfg[i].value);
        default:
          ch_evt[i] = 1'b0;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Flags
  // --------------------------------------------------------------------
  logic              wrap_flag;
  logic [NUM_CH-1:0] ch_flag;

  tef_flag u_wrap_flag
  (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_set  (wrap_evt),
    .i_clr  (i_wrap_clr),
    .o_flag (wrap_flag)
  );

  for (genvar g = 0; g < NUM_CH; g++)
  begin : g_ch
    tef_flag u_ch_flag
    (
      .i_clk  (i_clk),
      .i_rstn (i_rstn),
      .i_set  (ch_evt[g]),
      .i_clr  (i_ch_clr[g]),
      .o_flag (ch_flag[g])
    );
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  // Irq and flag outputs both lag the internal flags by one cycle to keep outputs registered
  logic              wrap_irq_ff;
  logic [NUM_CH-1:0] ch_irq_ff;
  logic              wrap_flag_ff;
  logic [NUM_CH-1:0] ch_flag_ff;

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      wrap_irq_ff  <= TEF_EN_RST;
      ch_irq_ff    <= '0;
      wrap_flag_ff <= TEF_FLAG_RST;
      ch_flag_ff   <= '0;
    end
    else
    begin
      wrap_irq_ff  <= wrap_flag && i_wrap_irq_enable;
      ch_irq_ff    <= ch_flag & i_channel_irq_enable;
      wrap_flag_ff <= wrap_flag;
      ch_flag_ff   <= ch_flag;
    end
  end

  assign o_count              = cnt_ff;
  assign o_count_down         = down_ff;
  assign o_counter_wrap_flag  = wrap_flag_ff;
  assign o_channel_event_flag = ch_flag_ff;
  assign o_wrap_irq           = wrap_irq_ff;
  assign o_channel_irq        = ch_irq_ff;

endmodule : tef_event_flags

//--- tef_event_flags_asserts.sv
// Checker for the flag timing of the timer event flag logic
`timescale 1ns/1ns
module tef_event_flags_asserts
  import tef_pkg::*;
#(
  parameter int NUM_CH = TEF_NUM_CH
)
(
  input wire logic                     i_clk,
  input wire logic                     i_rstn,
  input wire logic                     i_count_en,
  input wire logic [15:0]              i_modulus,
  input wire logic                     i_centered_pwm_select,
  input wire tef_ch_cfg_t [NUM_CH-1:0] i_ch_cfg,
  input wire logic [NUM_CH-1:0]        i_ch_pin,
  input wire logic                     i_wrap_irq_enable,
  input wire logic [NUM_CH-1:0]        i_channel_irq_enable,
  input wire tef_clr_t                 i_wrap_clr,
  input wire tef_clr_t [NUM_CH-1:0]    i_ch_clr,
  input wire logic [15:0]              o_count,
  input wire logic                     o_count_down,
  input wire logic                     o_counter_wrap_flag,
  input wire logic [NUM_CH-1:0]        o_channel_event_flag,
  input wire logic                     o_wrap_irq,
  input wire logic [NUM_CH-1:0]        o_channel_irq
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  logic top_free;
  logic top_mod;
  assign top_free = i_count_en && !i_centered_pwm_select
                    && i_modulus == TEF_MOD_FREE && o_count == TEF_CNT_ONES;
  assign top_mod  = i_count_en && !i_centered_pwm_select
                    && i_modulus != TEF_MOD_FREE && o_count == i_modulus;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  a_count_wraps_zero:
    assert property (top_free |=> o_count == TEF_CNT_ZERO)
    else $error("count did not wrap to zero");
  a_free_wrap_flag:
    assert property (top_free |-> ##2 o_counter_wrap_flag)
    else $error("free wrap flag missing");
  a_mod_wrap_flag:
    assert property (top_mod |-> ##2 o_counter_wrap_flag)
    else $error("modulus wrap flag missing");
  a_updown_wrap_flag:
    assert property (i_count_en && i_centered_pwm_select
      && o_count == i_modulus && i_modulus != TEF_MOD_FREE
      |=> o_count_down ##1 o_counter_wrap_flag)
    else $error("reversal flag missing");
  a_compare_flag:
    assert property (i_count_en && i_ch_cfg[0].mode == TEF_CH_COMPARE
      && o_count == i_ch_cfg[0].value |-> ##2 o_channel_event_flag[0])
    else $error("compare flag missing");
  a_pwm_match_flag:
    assert property (i_count_en && i_ch_cfg[NUM_CH-1].mode == TEF_CH_PWM
      && o_count == i_ch_cfg[NUM_CH-1].value
      |-> ##2 o_channel_event_flag[NUM_CH-1])
    else $error("pwm flag missing");
  a_flag_holds:
    assert property ($fell(o_counter_wrap_flag)
      |-> $past(i_wrap_clr.wr_zero, 2))
    else $error("wrap flag dropped without clear");
  a_wrap_irq_level:
    assert property (o_wrap_irq
      == (o_counter_wrap_flag && $past(i_wrap_irq_enable)))
    else $error("wrap irq does not follow flag");

  c_wrap_irq: cover property (o_wrap_irq);
  c_flag_cleared: cover property ($fell(o_counter_wrap_flag));
  c_both_channels: cover property (&o_channel_event_flag);
endmodule : tef_event_flags_asserts

bind tef_event_flags tef_event_flags_asserts #(.NUM_CH(NUM_CH))
  tef_event_flags_asserts_inst (.*);

//--- test_tef_event_flags.sv
// Self-checking bench for the timer event flag logic
`timescale 1ns/1ns
module test_tef_event_flags;
  import tef_pkg::*;
  logic              i_clk = 1'b0;
  logic              i_rstn = 1'b0;
  logic              i_count_en = 1'b0;
  logic [15:0]       i_modulus = 16'h0000;
  logic              i_centered_pwm_select = 1'b0;
  tef_ch_cfg_t [1:0] i_ch_cfg = '0;
  logic [1:0]        i_ch_pin = 2'h0;
  logic              i_wrap_irq_enable = 1'b1;
  logic [1:0]        i_channel_irq_enable = 2'h3;
  tef_clr_t          i_wrap_clr = '0;
  tef_clr_t [1:0]    i_ch_clr;
  logic [15:0]       o_count;
  logic              o_count_down;
  logic              o_counter_wrap_flag;
  logic              o_wrap_irq;
  logic [1:0]        o_channel_event_flag;
  logic [1:0]        o_channel_irq;
  int                failures = 0;
  int                comparisons = 0;
  tef_edge_t         e0 [3] = '{TEF_EDGE_RISE, TEF_EDGE_RISE, TEF_EDGE_ANY};
  tef_edge_t         e1 [3] = '{TEF_EDGE_FALL, TEF_EDGE_FALL, TEF_EDGE_OFF};
  logic [1:0]        pins [3] = '{2'h3, 2'h0, 2'h3};
  logic [1:0]        hits [3] = '{2'h1, 2'h2, 2'h1};

  // Every flag sees the same software access, so one sequence clears all
  assign i_ch_clr = {i_wrap_clr, i_wrap_clr};

  tef_event_flags #(.NUM_CH(2)) tef_event_flags_inst (.*);

  initial
  begin
    forever #2 i_clk = ~i_clk;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tick

  task automatic chk(input string nm, input logic [15:0] exp,
                     input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wrap_up;
    if (failures == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  task automatic wait_set(input bit ch, input int n);
    for (int k = 0; k < n; k++)
    begin
      tick(1);
      if ((ch ? &o_channel_event_flag : o_counter_wrap_flag) === 1'b1)
        return;
    end
    failures++;
    $display("mismatch wait_set expected 1 seen 0");
    wrap_up();
  endtask : wait_set

  // Read pulse (optional) then write-zero pulse on the next cycle
  task automatic clr(input bit with_rd);
    if (with_rd)
    begin
      i_wrap_clr = '{1'b1, 1'b0};
      tick(1);
    end
    i_wrap_clr = '{1'b0, 1'b1};
    tick(1);
    i_wrap_clr = '0;
  endtask : clr

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    tick(2);
    chk("rst", 16'h0, {o_counter_wrap_flag, o_channel_event_flag,
                       o_wrap_irq, o_channel_irq});
    i_rstn = 1'b1;
    i_count_en = 1'b1;
    wait_set(0, 70000);
    // Counting stops so no new wrap can disturb the clear checks
    i_count_en = 1'b0;
    chk("free", 16'h0001, o_count);
    chk("irq", 16'h1, o_wrap_irq);
    i_wrap_irq_enable = 1'b0;
    tick(1);
    chk("irq off", 16'h0, o_wrap_irq);
    i_wrap_irq_enable = 1'b1;
    clr(0);
    tick(1);
    chk("no rd", 16'h1, o_counter_wrap_flag);
    clr(1);
    tick(1);
    chk("clr", 16'h0, {o_counter_wrap_flag, o_wrap_irq});
    i_modulus = 16'h0004;
    i_count_en = 1'b1;
    wait_set(0, 20);
    i_count_en = 1'b0;
    chk("mod", 16'h0001, o_count);
    i_wrap_clr = '{1'b1, 1'b0};
    tick(1);
    i_wrap_clr = '0;
    i_count_en = 1'b1;
    tick(5);
    i_count_en = 1'b0;
    clr(0);
    tick(1);
    chk("restart", 16'h1, o_counter_wrap_flag);
    clr(1);
    tick(1);
    chk("clr2", 16'h0, o_counter_wrap_flag);
    i_centered_pwm_select = 1'b1;
    i_modulus = 16'h0003;
    i_count_en = 1'b1;
    wait_set(0, 20);
    i_count_en = 1'b0;
    chk("updn", 16'h0001, o_count);
    chk("down", 16'h1, o_count_down);
    clr(1);
    i_ch_cfg[0] = '{TEF_CH_COMPARE, TEF_EDGE_OFF, 16'h0002};
    i_ch_cfg[1] = '{TEF_CH_PWM, TEF_EDGE_OFF, 16'h0002};
    i_count_en = 1'b1;
    wait_set(1, 20);
    i_count_en = 1'b0;
    chk("match", 16'h0002, o_count);
    chk("ch irq", 16'h3, o_channel_irq);
    clr(1);
    tick(1);
    chk("ch clr", 16'h0, o_channel_event_flag);
    i_count_en = 1'b1;
    tick(1);
    i_count_en = 1'b0;
    tick(1);
    chk("down match", 16'h3, o_channel_event_flag);
    for (int s = 0; s < 3; s++)
    begin
      clr(1);
      i_ch_cfg[0] = '{TEF_CH_CAPTURE, e0[s], 16'h0000};
      i_ch_cfg[1] = '{TEF_CH_CAPTURE, e1[s], 16'h0000};
      i_ch_pin = pins[s];
      tick(4);
      chk("capture", {14'h0, hits[s]}, o_channel_event_flag);
    end
    wrap_up();
  end
endmodule : test_tef_event_flags
